// File: pkg/iosq_consts.svh
// constants of the i/o sequencer, pwm and strobe block
`ifndef IOSQ_CONSTS_SVH
`define IOSQ_CONSTS_SVH
`define ADDR_W 9
`define DATA_W 32
`define NUM_SRC 25
`define NUM_DST 18
`define NUM_FIELDS 4'd10
`define FLD_DURATION 4'h0
`define FLD_EXP_START 4'h1
`define FLD_EXP_STOP 4'h2
`define FLD_STB_START 4'h3
`define FLD_STB_STOP 4'h4
`define FLD_PWM_PERIOD 4'h5
`define FLD_PWM_ON0 4'h6
`define REG_CTRL 9'h100
`define REG_EXP_DELAY 9'h101
`define REG_STATUS 9'h102
`define REG_PL_BASE 9'h110
`define REG_MTX_BASE 9'h120
`define NUM_PL_REGS 9'h008
`define CTRL_LAST_LSB 0
`define CTRL_POL_LSB 4
`define CTRL_SWTRIG 8
`define CTRL_STORE 9
`define MTX_INV 8
`define MTX_FORCE 9
`define LAST_RST 4'hf
`define SRC_IN0 0
`define SRC_STROBE0 6
`define SRC_STROBE1 7
`define SRC_PWM_A 8
`define SRC_PWM_B 9
`define SRC_PULSE_A 12
`define SRC_PWM_C 13
`define SRC_PWM_D 14
`define SRC_ACTIVE 15
`define SRC_PULSE_B 18
`define SRC_STROBE2 20
`define SRC_STROBE3 21
`define DST_TRIGGER 6
`define DST_SEQ_TRIG 7
`define DST_PL0 13
`define CLK_PERIOD_NS 50
`define STROBE_MIN_NS 1000
`define STROBE_MAX_ON_MS 100
`endif

// File: pkg/iosq_pkg.sv
// types shared by the sequencer, pulse loops and register bus
`include "iosq_consts.svh"
package iosq_pkg;
  typedef struct packed {
    logic                wr;
    logic                rd;
    logic [`ADDR_W-1:0]  addr;
    logic [`DATA_W-1:0]  wdata;
  } reg_req_t;
  typedef struct packed {
    logic [3:0] pwm;
    logic       pulse_a;
    logic       pulse_b;
    logic       active;
  } seq_out_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DELAY, SEQ_RUN} seq_state_t;
  typedef enum logic [1:0] {PL_IDLE, PL_WAIT, PL_ON} pl_state_t;
endpackage

// File: verilog/line_mod.sv
// one switch matrix destination: source select, inverter, force (high, or low when inverted)
`timescale 1ns/1ps
`default_nettype none
module line_mod #(
  parameter int NUM_SRC = 25
) (
  input  wire logic [NUM_SRC-1:0] src,
  input  wire logic [4:0]         sel,
  input  wire logic               inv,
  input  wire logic               force_hi,
  output logic                    line
);
  logic picked;
  // out of range selects pick a quiet low source
  always_comb begin
    picked = (32'(sel) < NUM_SRC) ? src[sel] : 1'b0;
    if (force_hi) begin
      line = ~inv;
    end else begin
      line = picked ^ inv;
    end
  end
endmodule
`default_nettype wire

// File: verilog/pulse_loop.sv
// strobe pulse loop: delay, clamped duration, selectable polarity
`timescale 1ns/1ps
`default_nettype none
module pulse_loop
  import iosq_pkg::*;
#(
  parameter int MIN_CYC = 20,
  parameter int LIMIT   = 2000000
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        trig,
  input  wire logic [31:0] delay,
  input  wire logic [31:0] duration,
  input  wire logic        polarity,
  output logic             strobe
);
  if (MIN_CYC < 1 || LIMIT < MIN_CYC) $error("pulse_loop: bad limits");
  pl_state_t   state_reg, state_next;
  logic [31:0] cnt_reg, cnt_next, eff;
  logic        prev_reg, strobe_reg, strobe_next;
  // duration clamped to the supported span
  // never longer than the on-time ceiling
  always_comb begin
    eff = duration;
    if (duration < 32'(MIN_CYC)) eff = 32'(MIN_CYC);
    if (duration > 32'(LIMIT)) eff = 32'(LIMIT);
    state_next = state_reg;
    cnt_next = cnt_reg + 32'h1;
    unique case (state_reg)
      // delay counted from the logical rising edge
      PL_IDLE: begin
        cnt_next = 32'h0;
        if (trig && !prev_reg) begin
          state_next = (delay == 32'h0) ? PL_ON : PL_WAIT;
        end
      end
      PL_WAIT: begin
        if (cnt_reg + 32'h1 >= delay) begin
          state_next = PL_ON;
          cnt_next = 32'h0;
        end
      end
      PL_ON: begin
        if (cnt_reg + 32'h1 >= eff) begin
          state_next = PL_IDLE;
          cnt_next = 32'h0;
        end
      end
    endcase
    // polarity applied at the strobe line
    strobe_next = (state_next == PL_ON) ^ polarity;
  end
  // retriggers while busy are ignored
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= PL_IDLE;
      cnt_reg <= 32'h0;
      prev_reg <= 1'b0;
      strobe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      prev_reg <= trig;
      strobe_reg <= strobe_next;
    end
  end
  assign strobe = strobe_reg;
endmodule
`default_nettype wire

// File: verilog/io_sequencer_pwm_strobe.sv
// camera i/o timing: interval sequencer, pwm, strobes and switch matrix
`timescale 1ns/1ps
`default_nettype none
`include "iosq_consts.svh"
module io_sequencer_pwm_strobe
  import iosq_pkg::*;
#(
  parameter int NUM_STROBE      = 4,
  parameter int NUM_INTERVALS   = 16,
  parameter int STROBE_ON_LIMIT = (`STROBE_MAX_ON_MS * 1000000) / `CLK_PERIOD_NS
) (
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire iosq_pkg::reg_req_t  bus_req,
  output logic [`DATA_W-1:0]       rd_data,
  input  wire logic [3:0]          io_in,
  input  wire logic [3:0]          io_out_i,
  output logic [3:0]               io_out_o,
  output logic [3:0]               io_out_oe_n,
  output logic                     trigger_out,
  output logic                     expose_out,
  output logic                     nvm_store_req
);
  localparam int STROBE_MIN_CYC =
    (`STROBE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  // channel count depends on the model
  if (NUM_STROBE < 1 || NUM_STROBE > 4) $error("NUM_STROBE must be 1..4");
  if (NUM_INTERVALS < 1 || NUM_INTERVALS > 16) $error("NUM_INTERVALS must be 1..16");

  // pin synchroniser, only the second stage is read
  logic [7:0] sync1_reg, sync2_reg;
  logic [3:0] in_s, od_s;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= {io_out_i, io_in};
      sync2_reg <= sync1_reg;
    end
  end
  assign in_s = sync2_reg[3:0];
  assign od_s = sync2_reg[7:4];

  // interval table: sixteen entries of ten field words, each in a sixteen-word slot
  // every value held as a raw tic count
  logic [`DATA_W-1:0] tbl [0:255];

  // configuration and bus state
  logic [3:0]         last_reg, last_next;
  logic [3:0]         pol_reg, pol_next;
  logic [`DATA_W-1:0] exp_delay_reg, exp_delay_next;
  logic [`DATA_W-1:0] pl_delay_reg [0:3];
  logic [`DATA_W-1:0] pl_delay_next [0:3];
  logic [`DATA_W-1:0] pl_dur_reg [0:3];
  logic [`DATA_W-1:0] pl_dur_next [0:3];
  logic [9:0]         mtx_reg [0:`NUM_DST-1];
  logic [9:0]         mtx_next [0:`NUM_DST-1];
  logic [`DATA_W-1:0] rd_reg, rd_next;
  logic               swtrig_reg, swtrig_next;
  logic               store_reg, store_next;
  logic [`ADDR_W-1:0] pl_off, mtx_off;

  // sequencer state
  seq_state_t         state_reg, state_next;
  logic [3:0]         idx_reg, idx_next;
  logic [`DATA_W-1:0] tic_reg, tic_next;
  logic [`DATA_W-1:0] pwm_cnt_reg, pwm_cnt_next;
  logic               trig_prev_reg;
  seq_out_t           seq_reg, seq_next;
  logic [3:0]         pwm_hit;

  // matrix lines and registered pins
  logic [`NUM_SRC-1:0] src;
  logic [`NUM_DST-1:0] dst;
  logic [3:0]          strobe;
  logic [3:0]          oe_n_reg, oe_n_next;
  logic                trig_out_reg, trig_out_next;
  logic                seq_edge, run;

  // current interval fields, read straight from the table
  logic [`DATA_W-1:0] cur_dur, cur_exp_a, cur_exp_b;
  logic [`DATA_W-1:0] cur_stb_a, cur_stb_b, cur_period;
  assign cur_dur    = tbl[{idx_reg, `FLD_DURATION}];
  assign cur_exp_a  = tbl[{idx_reg, `FLD_EXP_START}];
  assign cur_exp_b  = tbl[{idx_reg, `FLD_EXP_STOP}];
  assign cur_stb_a  = tbl[{idx_reg, `FLD_STB_START}];
  assign cur_stb_b  = tbl[{idx_reg, `FLD_STB_STOP}];
  assign cur_period = tbl[{idx_reg, `FLD_PWM_PERIOD}];
  assign pl_off  = bus_req.addr - `REG_PL_BASE;
  assign mtx_off = bus_req.addr - `REG_MTX_BASE;

  // table writes; fields past the last one are dropped
  always_ff @(posedge clock) begin
    if (bus_req.wr && !bus_req.addr[8] && bus_req.addr[3:0] < `NUM_FIELDS) begin
      tbl[bus_req.addr[7:0]] <= bus_req.wdata;
    end
  end

  // register writes and read mux
  always_comb begin
    last_next = last_reg;
    pol_next = pol_reg;
    exp_delay_next = exp_delay_reg;
    pl_delay_next = pl_delay_reg;
    pl_dur_next = pl_dur_reg;
    mtx_next = mtx_reg;
    swtrig_next = 1'b0;
    store_next = 1'b0;
    rd_next = '0; // data stand one cycle only
    if (bus_req.wr) begin
      if (bus_req.addr == `REG_CTRL) begin
        last_next = bus_req.wdata[`CTRL_LAST_LSB +: 4];
        pol_next = bus_req.wdata[`CTRL_POL_LSB +: 4];
        swtrig_next = bus_req.wdata[`CTRL_SWTRIG];
        // request a save of the configuration
        store_next = bus_req.wdata[`CTRL_STORE];
      end else if (bus_req.addr == `REG_EXP_DELAY) begin
        exp_delay_next = bus_req.wdata;
      end else if (pl_off < `NUM_PL_REGS) begin
        if (pl_off[0]) begin
          pl_dur_next[pl_off[2:1]] = bus_req.wdata;
        end else begin
          pl_delay_next[pl_off[2:1]] = bus_req.wdata;
        end
      end else if (mtx_off < 9'(`NUM_DST)) begin
        mtx_next[mtx_off[4:0]] = bus_req.wdata[9:0];
      end
    end
    if (bus_req.rd) begin
      if (!bus_req.addr[8]) begin
        if (bus_req.addr[3:0] < `NUM_FIELDS) begin
          rd_next = tbl[bus_req.addr[7:0]];
        end
      end else if (bus_req.addr == `REG_CTRL) begin
        rd_next[`CTRL_LAST_LSB +: 4] = last_reg;
        rd_next[`CTRL_POL_LSB +: 4] = pol_reg;
      end else if (bus_req.addr == `REG_EXP_DELAY) begin
        rd_next = exp_delay_reg;
      end else if (bus_req.addr == `REG_STATUS) begin
        rd_next[0] = seq_reg.active;
        rd_next[1] = run;
        rd_next[7:4] = idx_reg;
        rd_next[11:8] = in_s;
        rd_next[15:12] = od_s;
        rd_next[19:16] = strobe;
        rd_next[23:20] = seq_reg.pwm;
      end else if (pl_off < `NUM_PL_REGS) begin
        rd_next = pl_off[0] ? pl_dur_reg[pl_off[2:1]] : pl_delay_reg[pl_off[2:1]];
      end else if (mtx_off < 9'(`NUM_DST)) begin
        rd_next[9:0] = mtx_reg[mtx_off[4:0]];
      end
    end
  end

  // all sources default to a matrix that passes nothing
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      last_reg <= `LAST_RST;
      pol_reg <= 4'h0;
      exp_delay_reg <= '0;
      pl_delay_reg <= '{default: '0};
      pl_dur_reg <= '{default: '0};
      mtx_reg <= '{default: 10'h01f};
      rd_reg <= '0;
      swtrig_reg <= 1'b0;
      store_reg <= 1'b0;
    end else begin
      last_reg <= last_next;
      pol_reg <= pol_next;
      exp_delay_reg <= exp_delay_next;
      pl_delay_reg <= pl_delay_next;
      pl_dur_reg <= pl_dur_next;
      mtx_reg <= mtx_next;
      rd_reg <= rd_next;
      swtrig_reg <= swtrig_next;
      store_reg <= store_next;
    end
  end

  // compare per channel against its on-time
  // each channel reads its own field of the interval
  for (genvar ch = 0; ch < 4; ch++) begin : g_pwm
    assign pwm_hit[ch] = pwm_cnt_reg < tbl[{idx_reg, `FLD_PWM_ON0 + 4'(ch)}];
  end

  assign run = (state_reg == SEQ_RUN);
  assign seq_edge = (dst[`DST_SEQ_TRIG] && !trig_prev_reg) || swtrig_reg;

  // sequencer stepping through the programmed intervals
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    tic_next = tic_reg;
    pwm_cnt_next = pwm_cnt_reg;
    unique case (state_reg)
      // integration waits the exposure delay after the edge
      SEQ_IDLE: begin
        if (seq_edge) begin
          tic_next = '0;
          idx_next = 4'h0;
          pwm_cnt_next = '0;
          state_next = (exp_delay_reg == '0) ? SEQ_RUN : SEQ_DELAY;
        end
      end
      SEQ_DELAY: begin
        if (tic_reg + 32'h1 >= exp_delay_reg) begin
          tic_next = '0;
          state_next = SEQ_RUN;
        end else begin
          tic_next = tic_reg + 32'h1;
        end
      end
      SEQ_RUN: begin
        // period wraps after the programmed tic count
        if (pwm_cnt_reg + 32'h1 >= cur_period) begin
          pwm_cnt_next = '0;
        end else begin
          pwm_cnt_next = pwm_cnt_reg + 32'h1;
        end
        // intervals run in order up to the last one
        if (tic_reg + 32'h1 >= cur_dur) begin
          tic_next = '0;
          pwm_cnt_next = '0;
          if (idx_reg == last_reg || 32'(idx_reg) == NUM_INTERVALS - 1) begin
            state_next = SEQ_IDLE;
          end else begin
            idx_next = idx_reg + 4'h1;
          end
        end else begin
          tic_next = tic_reg + 32'h1;
        end
      end
    endcase
    seq_next.pulse_a = run && tic_reg >= cur_exp_a && tic_reg < cur_exp_b;
    seq_next.pulse_b = run && tic_reg >= cur_stb_a && tic_reg < cur_stb_b;
    seq_next.pwm = run ? pwm_hit : 4'h0;
    seq_next.active = (state_next != SEQ_IDLE);
  end

  // a new trigger during a run is ignored
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= SEQ_IDLE;
      idx_reg <= 4'h0;
      tic_reg <= '0;
      pwm_cnt_reg <= '0;
      trig_prev_reg <= 1'b0;
      seq_reg <= '0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      tic_reg <= tic_next;
      pwm_cnt_reg <= pwm_cnt_next;
      trig_prev_reg <= dst[`DST_SEQ_TRIG];
      seq_reg <= seq_next;
    end
  end

  // source vector; unlisted sources belong to absent modules
  always_comb begin
    src = '0;
    src[`SRC_IN0 +: 4] = in_s;
    // pulse loop 0 presented on source 6
    src[`SRC_STROBE0] = strobe[0];
    src[`SRC_STROBE1] = strobe[1];
    src[`SRC_STROBE2] = strobe[2];
    src[`SRC_STROBE3] = strobe[3];
    src[`SRC_PWM_A] = seq_reg.pwm[0];
    src[`SRC_PWM_B] = seq_reg.pwm[1];
    src[`SRC_PWM_C] = seq_reg.pwm[2];
    src[`SRC_PWM_D] = seq_reg.pwm[3];
    src[`SRC_PULSE_A] = seq_reg.pulse_a;
    src[`SRC_PULSE_B] = seq_reg.pulse_b;
    src[`SRC_ACTIVE] = seq_reg.active;
  end

  for (genvar d = 0; d < `NUM_DST; d++) begin : g_mtx
    line_mod #(
      .NUM_SRC (`NUM_SRC)
    ) u_line (
      .src      (src),
      .sel      (mtx_reg[d][4:0]),
      .inv      (mtx_reg[d][`MTX_INV]),
      .force_hi (mtx_reg[d][`MTX_FORCE]),
      .line     (dst[d])
    );
  end

  // strobe channels beyond the model's count stay idle
  for (genvar ch = 0; ch < 4; ch++) begin : g_pl
    if (ch < NUM_STROBE) begin : g_on
      // destination 13 onward triggers the loops
      pulse_loop #(
        .MIN_CYC (STROBE_MIN_CYC),
        .LIMIT   (STROBE_ON_LIMIT)
      ) u_pl (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .trig     (dst[`DST_PL0 + ch]),
        .delay    (pl_delay_reg[ch]),
        .duration (pl_dur_reg[ch]),
        .polarity (pol_reg[ch]),
        .strobe   (strobe[ch])
      );
    end else begin : g_off
      assign strobe[ch] = 1'b0;
    end
  end

  // open drain: enable low pulls the pin low for a low line
  always_comb begin
    oe_n_next = dst[3:0];
    trig_out_next = dst[`DST_TRIGGER];
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      oe_n_reg <= 4'hf;
      trig_out_reg <= 1'b0;
    end else begin
      oe_n_reg <= oe_n_next;
      trig_out_reg <= trig_out_next;
    end
  end

  assign io_out_o = 4'h0; // open drain only ever drives low
  assign io_out_oe_n = oe_n_reg;
  assign trigger_out = trig_out_reg;
  assign expose_out = seq_reg.pulse_a;
  assign nvm_store_req = store_reg;
  assign rd_data = rd_reg;
endmodule
`default_nettype wire

// File: bench/io_sequencer_pwm_strobe_monitor.sv
// concurrent checks on the top ports of the i/o sequencer block
`timescale 1ns/1ps
`default_nettype none
`include "iosq_consts.svh"
module io_sequencer_pwm_strobe_monitor
  import iosq_pkg::*;
(
  input wire logic               clock,
  input wire logic               sys_rst,
  input wire iosq_pkg::reg_req_t bus_req,
  input wire logic [31:0]        rd_data,
  input wire logic [3:0]         io_in,
  input wire logic [3:0]         io_out_i,
  input wire logic [3:0]         io_out_o,
  input wire logic [3:0]         io_out_oe_n,
  input wire logic               trigger_out,
  input wire logic               expose_out,
  input wire logic               nvm_store_req
);
  logic [9:0]  mtx6_reg;
  logic [9:0]  mtx6_next;
  logic [31:0] expd_reg;
  logic [31:0] expd_next;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // shadow of the trigger line setup and exposure delay
  always_comb begin
    mtx6_next = mtx6_reg;
    expd_next = expd_reg;
    if (bus_req.wr && bus_req.addr == `REG_MTX_BASE + 9'd6)
      mtx6_next = bus_req.wdata[9:0];
    if (bus_req.wr && bus_req.addr == `REG_EXP_DELAY)
      expd_next = bus_req.wdata;
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mtx6_reg <= 10'h01f;
      expd_reg <= 32'h0;
    end else begin
      mtx6_reg <= mtx6_next;
      expd_reg <= expd_next;
    end
  end
  // setup held two cycles, input held past the two-flop synchroniser
  sequence s_settled;
    $stable(mtx6_reg) && $past(mtx6_reg, 2) == mtx6_reg && $stable(io_in[0])
      && $past(io_in[0], 2) == io_in[0] && $past(io_in[0], 3) == io_in[0]
      && $past(io_in[0], 4) == io_in[0];
  endsequence
  property p_mtx_pass;
    (mtx6_reg[9:8] == 2'b00 && mtx6_reg[4:0] == 5'd0) ##0 s_settled |-> trigger_out == io_in[0];
  endproperty
  a_mtx_pass: assert property (p_mtx_pass)
    else $error("trigger line does not follow input 0");
  property p_mtx_inv;
    (mtx6_reg[9:8] == 2'b01 && mtx6_reg[4:0] == 5'd0) ##0 s_settled |-> trigger_out == !io_in[0];
  endproperty
  a_mtx_inv: assert property (p_mtx_inv)
    else $error("inverted trigger line wrong");
  property p_mtx_force;
    (mtx6_reg[9:8] == 2'b10) ##0 s_settled |-> trigger_out;
  endproperty
  a_mtx_force: assert property (p_mtx_force)
    else $error("forced trigger line not high");
  property p_mtx_force_inv;
    (mtx6_reg[9:8] == 2'b11) ##0 s_settled |-> !trigger_out;
  endproperty
  a_mtx_force_inv: assert property (p_mtx_force_inv)
    else $error("forced inverted trigger line not low");
  property p_rd_idle;
    !$past(bus_req.rd) || $past(bus_req.addr) == 9'h1ff |-> rd_data == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a mapped read");
  property p_expd_rb;
    bus_req.rd && bus_req.addr == `REG_EXP_DELAY |=> rd_data == $past(expd_reg);
  endproperty
  a_expd_rb: assert property (p_expd_rb)
    else $error("exposure delay readback wrong");
  property p_nvm_pulse;
    nvm_store_req |-> $past(bus_req.wr) && $past(bus_req.addr) == `REG_CTRL
      && $past(bus_req.wdata[`CTRL_STORE]) ##1 !nvm_store_req;
  endproperty
  a_nvm_pulse: assert property (p_nvm_pulse)
    else $error("store request without cause or too long");
  property p_od_low;
    io_out_o == 4'h0;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open drain output drives high");
endmodule
bind io_sequencer_pwm_strobe io_sequencer_pwm_strobe_monitor u_mon (
  .clock(clock), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data(rd_data),
  .io_in(io_in), .io_out_i(io_out_i), .io_out_o(io_out_o), .io_out_oe_n(io_out_oe_n),
  .trigger_out(trigger_out), .expose_out(expose_out), .nvm_store_req(nvm_store_req)
);
`default_nettype wire

// File: bench/light_trig_model.sv
// trigger source and pulled-up light outputs at the far side
`timescale 1ns/1ps
`default_nettype none
module light_trig_model (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [3:0] lvl,
  input  wire logic       fire,
  input  wire logic [3:0] io_out_o,
  input  wire logic [3:0] io_out_oe_n,
  output logic [3:0]      io_in,
  output logic [3:0]      io_out_i
);
  logic [2:0] hold_reg;
  logic [2:0] hold_next;
  // a fire request becomes a four-cycle high, long enough for the synchroniser
  always_comb begin
    hold_next = (hold_reg != 3'h0) ? hold_reg - 3'h1 : 3'h0;
    if (fire)
      hold_next = 3'h4;
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      hold_reg <= 3'h0;
    else
      hold_reg <= hold_next;
  end
  // one rising edge per request on input 0
  assign io_in = lvl | {3'h0, hold_reg != 3'h0};
  // pull-up: a released pin reads high
  assign io_out_i = io_out_oe_n | io_out_o;
endmodule
`default_nettype wire

// File: bench/io_sequencer_pwm_strobe_tb.sv
// self-checking bench for the i/o sequencer, pwm and strobe block
`timescale 1ns/1ps
`default_nettype none
`include "iosq_consts.svh"
module io_sequencer_pwm_strobe_tb;
  import iosq_pkg::*;
  localparam int LIM = 100;
  localparam int WIN = 200;
  logic        clock;
  logic        sys_rst;
  reg_req_t    bus_req;
  logic [31:0] rd_data;
  logic [31:0] ctrl;
  logic [3:0]  io_in, io_out_i, io_out_o, io_out_oe_n, lvl;
  logic        trigger_out, expose_out, nvm_store_req, fire, win;
  logic [5:0]  obs;
  int          err_total, tests_run, cyc, f0;
  int          cnt_hi[6];
  int          first_hi[6];
  int          e[6];
  // per interval: duration, exp start/stop, strobe start/stop, period, on ch0..3
  int tbl[2][10] = '{'{10, 2, 5, 3, 6, 4, 2, 4, 0, 1}, '{6, 1, 3, 0, 6, 3, 1, 0, 3, 2}};
  // per case: delay, duration, polarity, expected high cycles in window
  // the window sees WIN + 1 edges; the first still shows the old idle level
  int pl[4][4] = '{'{5, 30, 0, 30}, '{12, 3, 0, 20}, '{0, 500, 0, LIM}, '{5, 30, 1, WIN - 30}};
  int stb_src[4] = '{`SRC_STROBE0, `SRC_STROBE1, `SRC_STROBE2, `SRC_STROBE3};

  io_sequencer_pwm_strobe #(.NUM_STROBE(4), .NUM_INTERVALS(16), .STROBE_ON_LIMIT(LIM)) u_dut (
    .clock(clock), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data(rd_data),
    .io_in(io_in), .io_out_i(io_out_i), .io_out_o(io_out_o), .io_out_oe_n(io_out_oe_n),
    .trigger_out(trigger_out), .expose_out(expose_out), .nvm_store_req(nvm_store_req)
  );
  light_trig_model u_far (
    .clock(clock), .sys_rst(sys_rst), .lvl(lvl), .fire(fire), .io_out_o(io_out_o),
    .io_out_oe_n(io_out_oe_n), .io_in(io_in), .io_out_i(io_out_i)
  );
  assign obs = {nvm_store_req, expose_out, io_out_oe_n};

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // high-cycle count and first high cycle per watched line
  always @(posedge clock) begin
    if (win) begin
      for (int b = 0; b < 6; b++) begin
        if (obs[b] === 1'b1) begin
          if (cnt_hi[b] == 0)
            first_hi[b] = cyc;
          cnt_hi[b]++;
        end
      end
      cyc++;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // idle cycle after each strobe so no signal is assigned twice in one step
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus_req <= '0;
    @(posedge clock);
  endtask
  task automatic rdc(input logic [8:0] a, input logic [31:0] exp, input string nm);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clock);
    bus_req <= '0;
    @(posedge clock);
    chk(nm, rd_data, exp);
  endtask
  task automatic setc(input logic [31:0] v);
    ctrl = v;
    wr(`REG_CTRL, v);
  endtask
  // open a window, then start by control write (cw nonzero) or far-side pulse
  task automatic run(input logic [31:0] cw, input int n);
    cnt_hi = '{default: 0};
    first_hi = '{default: 0};
    cyc = 0;
    win <= 1'b1;
    if (cw != 32'h0) begin
      wr(`REG_CTRL, cw);
    end else begin
      fire <= 1'b1;
      @(posedge clock);
      fire <= 1'b0;
    end
    repeat (n) @(posedge clock);
    win <= 1'b0;
    @(posedge clock);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // hang guard, well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    report_and_stop;
  end

  initial begin
    sys_rst = 1'b1;
    bus_req = '0;
    lvl = 4'h0;
    fire = 1'b0;
    win = 1'b0;
    ctrl = 32'h0;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    // values after reset, unmapped place reads zero
    rdc(`REG_CTRL, 32'hf, "ctrl_rst");
    rdc(`REG_EXP_DELAY, 32'h0, "expd_rst");
    rdc(`REG_MTX_BASE + 9'd6, 32'h1f, "mtx_rst");
    rdc(9'h1ff, 32'h0, "unmapped");
    chk("trig_rst", {31'h0, trigger_out}, 32'h0);
    // trigger line: every inverter and force setting against both input levels
    for (int k = 0; k < 8; k++) begin
      lvl <= {3'h0, k[0]};
      wr(`REG_MTX_BASE + 9'd6, {22'h0, k[2:1], 8'h00});
      repeat (6) @(posedge clock);
      chk("trig_line", {31'h0, trigger_out}, {31'h0, k[2] ? !k[1] : k[0] ^ k[1]});
      rdc(`REG_STATUS, {23'h0, k[0], 8'h00}, "status_in");
    end
    lvl <= 4'h0;
    // two intervals as tic counts, exposure kept inside each duration
    for (int i = 0; i < 2; i++)
      for (int f = 0; f < 10; f++)
        wr({1'b0, i[3:0], f[3:0]}, tbl[i][f]);
    e = '{default: 0};
    for (int i = 0; i < 2; i++) begin
      for (int t = 0; t < tbl[i][0]; t++) begin
        for (int c = 0; c < 4; c++)
          if (t % tbl[i][5] < tbl[i][6 + c]) e[c]++;
        if (t >= tbl[i][1] && t < tbl[i][2]) e[4]++;
        if (t >= tbl[i][3] && t < tbl[i][4]) e[5]++;
      end
    end
    wr(`REG_MTX_BASE, `SRC_PWM_A);
    wr(`REG_MTX_BASE + 9'd1, `SRC_PWM_B);
    wr(`REG_MTX_BASE + 9'd2, `SRC_PWM_C);
    setc(32'h1);
    for (int r = 0; r < 2; r++) begin
      wr(`REG_EXP_DELAY, r ? 32'd7 : 32'd0);
      wr(`REG_MTX_BASE + 9'd3, r ? `SRC_PWM_D : `SRC_PULSE_B);
      run(ctrl | 32'h100, 60);
      for (int c = 0; c < 3; c++)
        chk("pwm_hi", cnt_hi[c], e[c]);
      chk("dest3_hi", cnt_hi[3], r ? e[3] : e[5]);
      chk("exp_hi", cnt_hi[4], e[4]);
      if (r)
        chk("exp_delay", first_hi[4] - f0, 7);
      f0 = first_hi[4];
    end
    // store request is a single pulse
    run(ctrl | 32'h200, 10);
    chk("nvm_pulses", cnt_hi[5], 1);
    // each pulse loop: delay, minimum, clamp and polarity
    for (int ch = 0; ch < 4; ch++) begin
      wr(`REG_MTX_BASE + 9'd13 + ch[8:0], 32'h0);
      wr(`REG_MTX_BASE, stb_src[ch]);
      for (int k = 0; k < 4; k++) begin
        wr(`REG_PL_BASE + 9'(2 * ch), pl[k][0]);
        wr(`REG_PL_BASE + 9'(2 * ch + 1), pl[k][1]);
        setc(32'h1 | (pl[k][2] << (4 + ch)));
        run(32'h0, WIN);
        chk("strobe_hi", cnt_hi[0], pl[k][3]);
        if (k == 1)
          chk("strobe_delay", first_hi[0] - f0, 7);
        f0 = first_hi[0];
      end
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
